// ==== hdl/tsd_pkg.sv ====
package tsd_pkg;
  // ****************************************************************
  // trellis geometry
  // ****************************************************************
  localparam int N_STATES    = 32;           // one survivor per state
  localparam int SS_LEN      = 32;           // bits per survivor
  localparam int K_MAX       = 6;            // longest constraint length
  localparam int DEPTH_STEP  = 4;            // taps every fourth stage
  localparam int MAJ_LIMIT   = 16;           // ones needed for a one
  localparam int DEC_PIPE    = 2;            // compare-to-load stages
  // ****************************************************************
  // latency figures in bits
  // ****************************************************************
  localparam logic [5:0] LAT_FIX_THIRD = 6'h10;  // 16 bits
  localparam logic [5:0] LAT_FIX_HALF  = 6'h11;  // 17 bits
  // ****************************************************************
  // branch synchronizer settings
  // ****************************************************************
  localparam logic [5:0] THR_LONG  = 6'h3C;  // 60 for k of 5 or 6
  localparam logic [5:0] THR_SHORT = 6'h1E;  // 30 for k of 3 or 4
  localparam logic [5:0] CHK_K6    = 6'h20;  // 32
  localparam logic [5:0] CHK_K5    = 6'h1B;  // 27
  localparam logic [5:0] CHK_K4    = 6'h16;  // 22
  localparam logic [5:0] CHK_K3    = 6'h10;  // 16
  // ****************************************************************
  // register port map
  // ****************************************************************
  localparam logic [7:0] CTRL_OFF  = 8'h00;
  localparam logic [7:0] STAT_OFF  = 8'h04;
  localparam logic [7:0] POLY_OFF  = 8'h08;
  localparam int CTRL_DEPTH_LSB = 0;         // 3 bits, depth select
  localparam int CTRL_QUANT_LSB = 4;         // 2 bits, quantization
  localparam int CTRL_K_LSB     = 8;         // 2 bits, constraint length
  localparam logic [2:0]  DEPTH_RST = 3'h7;  // full 32-stage depth
  localparam logic [1:0]  QUANT_RST = 2'h3;  // three-bit soft data
  localparam logic [1:0]  K_RST     = 2'h3;  // k = 6
  localparam logic [17:0] POLY_RST  = 18'h00000;
  // ****************************************************************
  // forced pattern for the idle third word at rate one-half
  // ****************************************************************
  localparam logic [2:0] IDLE_WORD = 3'h4;
endpackage : tsd_pkg

// ==== hdl/tsd_top.sv ====
// Operation
// - thirty-two survivor registers, thirty-two bits each
// - upper decision: shift register s/2, insert zero
// - lower decision: take register s/2 plus sixteen, insert one
// - decision zero upper branch, one lower
// - two branch delays from compare to load
// - majority taps at depth four to thirty-two
// - count ones, pipelined over four branches
// - output one when count reaches sixteen
// - rate third latency sixteen plus depth delay
// - rate half latency seventeen plus depth delay
// - three weighted lines give variable delay
// - constraint length up to six, plugged polynomials
// - sync threshold sixty or thirty by length
// - sync check depth thirty-two down to sixteen
// - unused quantization bits add equally everywhere
// - rate half forces third word equal
// - forward word msbs and clock onward
// - corrected bits leave with in-phase clock
// - decision bit is newest survivor bit
`timescale 1ns/10ps
`default_nettype none
module tsd_top
  import tsd_pkg::*;
#(
  parameter int WORD_W = 3,
  parameter int N_WORD = 3
) (
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      link_clk,
  input  wire logic [WORD_W*N_WORD-1:0]  link_data,
  input  wire logic                      rate_half,
  input  wire logic [N_STATES-1:0]       cmp_dec,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [31:0]               reg_rdata,
  output logic      [WORD_W*N_WORD-1:0]  cond_data,
  output logic      [17:0]               gen_poly,
  output logic      [5:0]                bsync_thr,
  output logic      [5:0]                bsync_chk,
  output logic      [2:0]                delay_code,
  output logic      [5:0]                total_lat,
  output logic      [N_WORD-1:0]         tree_data,
  output logic                           tree_clk,
  output logic                           dec_data,
  output logic                           dec_clk
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic                     clk_s1;
  logic                     clk_s2;
  logic                     clk_s3;
  logic [WORD_W*N_WORD-1:0] dat_s1;
  logic [WORD_W*N_WORD-1:0] dat_s2;
  logic                     half_s1;
  logic                     half_s2;
  logic                     tick;

  // link pins are asynchronous to ref_clk, two flops before use
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      clk_s1  <= 1'b0;
      clk_s2  <= 1'b0;
      clk_s3  <= 1'b0;
      dat_s1  <= '0;
      dat_s2  <= '0;
      half_s1 <= 1'b0;
      half_s2 <= 1'b0;
    end else begin
      clk_s1  <= link_clk;
      clk_s2  <= clk_s1;
      clk_s3  <= clk_s2;
      dat_s1  <= link_data;
      dat_s2  <= dat_s1;
      half_s1 <= rate_half;
      half_s2 <= half_s1;
    end
  end

  // one branch per rising link clock edge
  assign tick = clk_s2 & ~clk_s3;

  // ****************************************************************
  // control registers
  // ****************************************************************
  logic [2:0] depth_sel;
  logic [1:0] quant_sel;
  logic [1:0] k_sel;

  // settings change mid-stream glitch the decode; software should idle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      depth_sel <= DEPTH_RST;
      quant_sel <= QUANT_RST;
      k_sel     <= K_RST;
      gen_poly  <= POLY_RST;
    end else if (reg_wr && reg_addr == CTRL_OFF) begin
      depth_sel <= reg_wdata[CTRL_DEPTH_LSB +: 3];
      quant_sel <= reg_wdata[CTRL_QUANT_LSB +: 2];
      k_sel     <= reg_wdata[CTRL_K_LSB +: 2];
    end else if (reg_wr && reg_addr == POLY_OFF) begin
      gen_poly  <= reg_wdata[17:0];  // plugged generator taps, k up to six
    end
  end

  // ****************************************************************
  // branch synchronizer settings
  // ****************************************************************
  // k_sel: 0 is k3, 1 is k4, 2 is k5, 3 is k6
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bsync_thr <= THR_LONG;
      bsync_chk <= CHK_K6;
    end else begin
      bsync_thr <= k_sel[1] ? THR_LONG : THR_SHORT;
      unique case (k_sel)
        2'h0: bsync_chk <= CHK_K3;
        2'h1: bsync_chk <= CHK_K4;
        2'h2: bsync_chk <= CHK_K5;
        2'h3: bsync_chk <= CHK_K6;
      endcase
    end
  end

  // ****************************************************************
  // input word conditioning
  // ****************************************************************
  logic [WORD_W*N_WORD-1:0] next_cond;

  // unused low bits take the inverse of the msb, so a word sits at
  // the same distance from both hard levels whatever it carries
  always_comb begin
    next_cond = dat_s2;
    for (int w = 0; w < N_WORD; w++) begin
      if (quant_sel == 2'h1) begin
        next_cond[w*WORD_W +: 2] = {2{~dat_s2[w*WORD_W+2]}};
      end else if (quant_sel == 2'h2) begin
        next_cond[w*WORD_W] = ~dat_s2[w*WORD_W+2];
      end
    end
    if (half_s2) begin
      next_cond[WORD_W*N_WORD-1 -: WORD_W] = IDLE_WORD;
    end
  end

  // words and msbs change once per branch
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cond_data <= '0;
      tree_data <= '0;
    end else if (tick) begin
      cond_data <= next_cond;
      for (int w = 0; w < N_WORD; w++) begin
        tree_data[w] <= dat_s2[w*WORD_W+WORD_W-1];
      end
    end
  end

  // ****************************************************************
  // decision pipeline
  // ****************************************************************
  logic [N_STATES-1:0] dec_p1;
  logic [N_STATES-1:0] dec_p2;

  // one stage each side of the drawer cable
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dec_p1 <= '0;
      dec_p2 <= '0;
    end else if (tick) begin
      dec_p1 <= cmp_dec;
      dec_p2 <= dec_p1;
    end
  end

  // ****************************************************************
  // survivor registers
  // ****************************************************************
  logic [SS_LEN-1:0]   ss [N_STATES];
  logic [N_STATES-1:0] tap;

  // bit 0 is the newest bit; state s draws from s/2 or s/2 + 16
  for (genvar s = 0; s < N_STATES; s++) begin : g_ss
    localparam int UP = s / 2;
    localparam int LO = s / 2 + N_STATES / 2;
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        ss[s] <= '0;
      end else if (tick) begin
        if (dec_p2[s]) begin
          ss[s] <= {ss[LO][SS_LEN-2:0], 1'b1};
        end else begin
          ss[s] <= {ss[UP][SS_LEN-2:0], 1'b0};
        end
      end
    end
    assign tap[s] = ss[s][DEPTH_STEP*depth_sel + DEPTH_STEP - 1];
  end

  // ****************************************************************
  // majority decision
  // ****************************************************************
  logic [N_STATES-1:0] tap_q;
  logic [2:0]          grp [N_STATES/4];
  logic [4:0]          half_sum [2];
  logic [5:0]          total;

  assign total = {1'b0, half_sum[0]} + {1'b0, half_sum[1]};

  // four branch stages trade latency for short adder paths
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tap_q    <= '0;
      half_sum <= '{default: '0};
      dec_data <= 1'b0;
    end else if (tick) begin
      tap_q       <= tap;
      half_sum[0] <= 5'(grp[0]) + 5'(grp[1]) + 5'(grp[2]) + 5'(grp[3]);
      half_sum[1] <= 5'(grp[4]) + 5'(grp[5]) + 5'(grp[6]) + 5'(grp[7]);
      dec_data    <= (total >= 6'(MAJ_LIMIT));
    end
  end

  // groups of four taps form the second stage
  for (genvar g = 0; g < N_STATES/4; g++) begin : g_grp
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        grp[g] <= '0;
      end else if (tick) begin
        grp[g] <= 3'(tap_q[4*g]) + 3'(tap_q[4*g+1])
                + 3'(tap_q[4*g+2]) + 3'(tap_q[4*g+3]);
      end
    end
  end

  // ****************************************************************
  // output clocks and latency report
  // ****************************************************************
  // rises in the same ref_clk cycle as dec_data and tree_data move
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dec_clk  <= 1'b0;
      tree_clk <= 1'b0;
    end else begin
      dec_clk  <= clk_s2;
      tree_clk <= clk_s2;
    end
  end

  // variable delay is four bits per depth step
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      delay_code <= DEPTH_RST;
      total_lat  <= LAT_FIX_THIRD;
    end else begin
      delay_code <= depth_sel;
      if (half_s2) begin
        total_lat <= LAT_FIX_HALF + {1'b0, depth_sel, 2'b00};
      end else begin
        total_lat <= LAT_FIX_THIRD + {1'b0, depth_sel, 2'b00};
      end
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  // unmapped addresses read zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      if (reg_addr == CTRL_OFF) begin
        reg_rdata[CTRL_DEPTH_LSB +: 3] <= depth_sel;
        reg_rdata[CTRL_QUANT_LSB +: 2] <= quant_sel;
        reg_rdata[CTRL_K_LSB +: 2]     <= k_sel;
      end else if (reg_addr == STAT_OFF) begin
        reg_rdata[5:0]   <= total_lat;
        reg_rdata[11:6]  <= bsync_thr;
        reg_rdata[17:12] <= bsync_chk;
        reg_rdata[18]    <= dec_data;
        reg_rdata[19]    <= half_s2;
        reg_rdata[25:20] <= total;
      end else if (reg_addr == POLY_OFF) begin
        reg_rdata[17:0] <= gen_poly;
      end
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule : tsd_top
`default_nettype wire

// ==== test/tsd_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// port relations of the decision stage
// ****************************************
module tsd_chk
  import tsd_pkg::*;
#(
  parameter int WORD_W = 3,
  parameter int N_WORD = 3
) (
  input wire logic                     ref_clk,
  input wire logic                     sys_rst,
  input wire logic                     rate_half,
  input wire logic [7:0]               reg_addr,
  input wire logic [31:0]              reg_wdata,
  input wire logic                     reg_wr,
  input wire logic [WORD_W*N_WORD-1:0] cond_data,
  input wire logic [5:0]               bsync_thr,
  input wire logic [5:0]               bsync_chk,
  input wire logic [2:0]               delay_code,
  input wire logic [5:0]               total_lat,
  input wire logic [N_WORD-1:0]        tree_data,
  input wire logic                     tree_clk,
  input wire logic                     dec_data,
  input wire logic                     dec_clk
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // control write, then a settled rate ahead of a branch
  sequence ctrl_wr;
    reg_wr && reg_addr == CTRL_OFF;
  endsequence
  sequence rate_held;
    rate_half [*8] ##1 $rose(tree_clk);
  endsequence
  function automatic logic [5:0] chk_of(input logic [1:0] k);
    return k == 2'h3 ? CHK_K6 : k == 2'h2 ? CHK_K5 : k == 2'h1 ? CHK_K4 : CHK_K3;
  endfunction : chk_of
  depth_load_a: assert property (ctrl_wr |-> ##2 delay_code == $past(reg_wdata[2:0], 2))
    else $error("delay code missed control write");
  check_load_a: assert property (ctrl_wr |-> ##2 bsync_chk == chk_of($past(reg_wdata[9:8], 2)))
    else $error("check depth missed control write");
  thr_pair_a: assert property (bsync_thr == (bsync_chk > CHK_K4 ? THR_LONG : THR_SHORT))
    else $error("threshold does not suit check depth");
  // first edge after release still shows the reset latency
  lat_sum_a: assert property (!$past(sys_rst) |->
    total_lat == {1'b0, delay_code, 2'b00} + LAT_FIX_THIRD ||
    total_lat == {1'b0, delay_code, 2'b00} + LAT_FIX_HALF)
    else $error("latency not fixed part plus depth");
  clk_pair_a: assert property (dec_clk == tree_clk)
    else $error("output clock out of phase");
  tree_hold_a: assert property ($changed(tree_data) |-> $rose(tree_clk))
    else $error("forwarded bits moved off branch");
  dec_hold_a: assert property ($changed(dec_data) |-> $rose(dec_clk))
    else $error("decoded bit moved off its clock");
  idle_word_a: assert property (rate_held |-> cond_data[8:6] == IDLE_WORD)
    else $error("third word not neutral at rate half");
  rst_vals_a: assert property (disable iff (1'b0) $fell(sys_rst) |->
    !dec_data && delay_code == DEPTH_RST && bsync_chk == CHK_K6)
    else $error("reset state wrong");
endmodule : tsd_chk
bind tsd_top tsd_chk #(.WORD_W(WORD_W), .N_WORD(N_WORD)) u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .rate_half(rate_half), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .cond_data(cond_data), .bsync_thr(bsync_thr),
  .bsync_chk(bsync_chk), .delay_code(delay_code), .total_lat(total_lat),
  .tree_data(tree_data), .tree_clk(tree_clk), .dec_data(dec_data), .dec_clk(dec_clk));
`default_nettype wire

// ==== test/tsd_bsync_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// upstream bit synchronizer stand-in
// ****************************************
module tsd_bsync_model (
  input  wire logic       run,
  input  wire logic [8:0] word,
  output logic            link_clk,
  output logic [8:0]      link_data
);
  // new word on the fall, so it is long settled at the rise
  initial begin
    link_clk = 1'b0;
    link_data = 9'h000;
    #7;
    forever begin
      if (run) begin
        link_data = word;
        #100 link_clk = 1'b1;
        #100 link_clk = 1'b0;
      end else begin
        #100 link_data = ~link_data; // parked: data is not to be trusted
      end
    end
  end
endmodule : tsd_bsync_model
`default_nettype wire

// ==== test/tb_tsd_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_tsd_top
  import tsd_pkg::*;
;
  logic        ref_clk, sys_rst, rate_half, reg_wr, reg_rd, run;
  logic        link_clk, tree_clk, dec_clk, dec_data;
  logic [7:0]  reg_addr;
  logic [8:0]  word, link_data, cond_data;
  logic [31:0] cmp_dec, reg_wdata, reg_rdata, rd_val, seed;
  logic [17:0] gen_poly;
  logic [5:0]  bsync_thr, bsync_chk, total_lat;
  logic [2:0]  delay_code, tree_data;
  logic [5:0]  chk_tab [4] = '{CHK_K3, CHK_K4, CHK_K5, CHK_K6};
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  tsd_top u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .link_data(link_data), .rate_half(rate_half), .cmp_dec(cmp_dec), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cond_data(cond_data), .gen_poly(gen_poly), .bsync_thr(bsync_thr),
    .bsync_chk(bsync_chk), .delay_code(delay_code), .total_lat(total_lat),
    .tree_data(tree_data), .tree_clk(tree_clk), .dec_data(dec_data), .dec_clk(dec_clk));
  tsd_bsync_model u_bsync (.run(run), .word(word), .link_clk(link_clk),
    .link_data(link_data));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rd_val = reg_rdata;
  endtask : rd
  // settled exchange: constant decisions overwrite all 32 stages
  function automatic int ones_at(input logic [31:0] c, input int d);
    logic [31:0] ss [32];
    logic [31:0] nx [32];
    int n;
    n = 0;
    foreach (ss[s]) ss[s] = 32'h0;
    repeat (40) begin
      foreach (nx[s]) nx[s] = ((c[s] ? ss[s/2+16] : ss[s/2]) << 1) | 32'(c[s]);
      ss = nx;
    end
    foreach (ss[s]) n += int'(ss[s][4*d+3]);
    return n;
  endfunction : ones_at
  // unused low bits follow the inverted sign bit
  function automatic logic [8:0] cond_of(input logic [8:0] w, input int q, input logic r);
    logic [8:0] o;
    logic m;
    for (int i = 0; i < 3; i++) begin
      m = w[3*i+2];
      o[3*i+:3] = q == 1 ? {m, ~m, ~m} : q == 2 ? {m, w[3*i+1], ~m} : w[3*i+:3];
    end
    if (r) o[8:6] = IDLE_WORD;
    return o;
  endfunction : cond_of
  task automatic results();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  // ****************************************
  // clock, hang guard, main sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // a stuck branch clock would otherwise hang the run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    int q, k, n;
    logic [31:0] c, p;
    logic [5:0] lat, thr;
    seed = 32'd95256;
    {sys_rst, run, rate_half, reg_wr, reg_rd} = 5'h10;
    {reg_addr, reg_wdata, cmp_dec, word} = '0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    run <= 1'b1;
    p = rnd();
    wr(POLY_OFF, p);
    rd(POLY_OFF);
    check(32'(gen_poly), {14'h0, p[17:0]});
    check(rd_val, {14'h0, p[17:0]});
    rd(8'h0C);
    check(rd_val, 32'h0);
    // every depth, length, width and both rates
    for (int ph = 0; ph < 8; ph++) begin
      k = ph % 4;
      q = ph / 2;
      c = rnd();
      p = rnd();
      @(posedge ref_clk);
      cmp_dec <= c;
      word <= p[8:0];
      rate_half <= (ph >= 4);
      wr(CTRL_OFF, 32'(ph) | (32'(q) << 4) | (32'(k) << 8));
      repeat (48) @(posedge tree_clk);
      @(negedge ref_clk);
      n = ones_at(c, ph);
      lat = 6'(4 * ph) + (ph >= 4 ? LAT_FIX_HALF : LAT_FIX_THIRD);
      thr = k > 1 ? THR_LONG : THR_SHORT;
      check(32'(delay_code), 32'(ph));
      check(32'(total_lat), 32'(lat));
      check(32'(bsync_thr), 32'(thr));
      check(32'(bsync_chk), 32'(chk_tab[k]));
      check(32'(cond_data), 32'(cond_of(p[8:0], q, ph >= 4)));
      check(32'(tree_data), {29'h0, p[8], p[5], p[2]});
      check(32'(dec_data), 32'(n >= 16));
      rd(STAT_OFF);
      check(32'(rd_val[25:0]), {6'h0, 6'(n), ph >= 4, n >= 16, chk_tab[k], thr, lat});
      rd(CTRL_OFF);
      check(rd_val, 32'(ph) | (32'(q) << 4) | (32'(k) << 8));
    end
    results();
  end
endmodule : tb_tsd_top
`default_nettype wire
